// *** rtl/umpa_defs.svh ***
// Constants of the addressed multi-drop serial transceiver.
// Assumes inclusion by bare name from the package and the top module.
`ifndef UMPA_DEFS_SVH
`define UMPA_DEFS_SVH
`define UMPA_OFF_DATA 8'h00
`define UMPA_OFF_CTRL 8'h04
`define UMPA_OFF_BAUD 8'h08
`define UMPA_OFF_ISTAT 8'h0C
`define UMPA_OFF_ICLR 8'h10
`define UMPA_OFF_IEN 8'h14
`define UMPA_CTRL_RST 9'h000
`define UMPA_BAUD_RST 12'h000
`define UMPA_IRQ_RST 4'h0
`define UMPA_CS_9BIT 3'h7
`define UMPA_CS_8BIT 3'h3
`define UMPA_MIN_BITS 4'h5
`define UMPA_NINE_BITS 4'h9
`define UMPA_SPB_NORM 5'h10
`define UMPA_SPB_DBL 5'h08
`define UMPA_RXSH_W 4'hA
`endif

// *** rtl/umpa_pkg.sv ***
// Types of the addressed multi-drop serial transceiver.
// Assumes the defs header sits beside it on the include path.
`include "umpa_defs.svh"
package umpa_pkg;
   typedef struct packed {
      logic [7:0] paddr;
      logic pwrite;
      logic [31:0] pwdata;
      logic psel;
      logic penable;
   } umpa_apb_req_t;
   typedef struct packed {
      logic rx_en;
      logic tx_en;
      logic tx_ninth_bit;
      logic [2:0] char_size_code;
      logic stop_bits_select;
      logic double_speed_sel;
      logic addr_filter_en;
   } umpa_ctrl_t;
   typedef struct packed {
      logic overrun;
      logic frame_err;
      logic tx_complete_flag;
      logic rx_complete_flag;
   } umpa_irq_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} umpa_rx_state_t;
   typedef enum logic {TX_IDLE, TX_SEND} umpa_tx_state_t;
endpackage : umpa_pkg

// *** rtl/umpa_top.sv ***
// Serial transceiver with address-frame filtering, registers on APB.
// Assumes rxd is already synchronous to pclk and idles high.
`timescale 1ns/100ps
`default_nettype none
`include "umpa_defs.svh"

// How it works
// - Transmitted ninth bit equals tx_ninth_bit: 1 address, 0 data.
// - With filter on, address frames are stored and flag completion normally.
// - Filter off accepts data frames; filter on drops them silently.
// - One character-size setting serves both transmitter and receiver.
// - Divisor zero gives the fastest exact rate in each speed mode.
// - Frame type is ninth bit, or first stop bit for short characters.
// - Filter enable affects only the receiver.
module umpa_top (
   input wire logic pclk, // System clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire umpa_pkg::umpa_apb_req_t apb_req, // APB request group
   output var logic [31:0] prdata, // APB read data
   output var logic pready, // APB ready
   output var logic pslverr, // APB error on unmapped address
   input wire logic rxd, // Serial receive line
   output var logic txd, // Serial transmit line
   output var logic irq // Level interrupt
);
   import umpa_pkg::*;

   umpa_ctrl_t ctrl_reg;
   logic [11:0] baud_reg;
   umpa_irq_t irq_stat_reg;
   logic [3:0] ien_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic irq_reg;
   logic txd_reg;
   logic [11:0] presc_reg;
   umpa_tx_state_t tx_state_reg;
   logic [11:0] tx_shift_reg;
   logic [3:0] tx_left_reg;
   logic [4:0] tx_cnt_reg;
   umpa_rx_state_t rx_state_reg;
   logic [9:0] rx_shift_reg;
   logic [3:0] rx_left_reg;
   logic [4:0] rx_cnt_reg;
   logic [7:0] rx_data_reg;
   logic rx_ninth_reg;

   // Bus decode
   wire logic acc_first = apb_req.psel & apb_req.penable & ~pready_reg;
   wire logic acc_done = apb_req.psel & apb_req.penable & pready_reg;
   wire logic wr_done = acc_done & apb_req.pwrite;
   wire logic rd_done = acc_done & ~apb_req.pwrite;
   wire logic hit_data = apb_req.paddr == `UMPA_OFF_DATA;
   wire logic hit_ctrl = apb_req.paddr == `UMPA_OFF_CTRL;
   wire logic hit_baud = apb_req.paddr == `UMPA_OFF_BAUD;
   wire logic hit_istat = apb_req.paddr == `UMPA_OFF_ISTAT;
   wire logic hit_iclr = apb_req.paddr == `UMPA_OFF_ICLR;
   wire logic hit_ien = apb_req.paddr == `UMPA_OFF_IEN;
   wire logic mapped = hit_data | hit_ctrl | hit_baud | hit_istat | hit_iclr | hit_ien;
   wire logic tx_busy = tx_state_reg == TX_SEND;

   wire logic [31:0] rd_word =
      hit_data ? {23'h000000, rx_ninth_reg, rx_data_reg} :
      hit_ctrl ? {21'h000000, tx_busy, rx_ninth_reg, ctrl_reg} :
      hit_baud ? {20'h00000, baud_reg} :
      hit_istat ? {28'h0000000, irq_stat_reg} :
      hit_ien ? {28'h0000000, ien_reg} : 32'h00000000;

   // Character size shared by both directions
   wire logic [3:0] nbits = (ctrl_reg.char_size_code == `UMPA_CS_9BIT) ? `UMPA_NINE_BITS :
      (ctrl_reg.char_size_code > `UMPA_CS_8BIT) ? `UMPA_MIN_BITS + 4'(`UMPA_CS_8BIT) :
      `UMPA_MIN_BITS + {1'b0, ctrl_reg.char_size_code};
   wire logic nine = nbits == `UMPA_NINE_BITS;

   // Baud prescaler; divisor zero ticks every clock, giving the fastest exact rate
   wire logic tick = presc_reg == 12'h000;
   wire logic [4:0] spb = ctrl_reg.double_speed_sel ? `UMPA_SPB_DBL : `UMPA_SPB_NORM;
   wire logic [4:0] spb_last = spb - 5'h01;
   wire logic [4:0] spb_half = (spb >> 1) - 5'h01;

   // Transmitter: filter setting deliberately not consulted
   wire logic tx_load = wr_done & hit_data & ctrl_reg.tx_en & ~tx_busy;
   wire logic [8:0] tx_word = nine ? {ctrl_reg.tx_ninth_bit, apb_req.pwdata[7:0]} :
      {1'b0, apb_req.pwdata[7:0]};
   wire logic [11:0] tx_low_mask = (12'h001 << (4'(nbits + 4'h1))) - 12'h001;
   wire logic [11:0] tx_frame = ({2'b11, tx_word, 1'b0} & tx_low_mask) | ~tx_low_mask;
   wire logic [3:0] tx_total = 4'(nbits + 4'h1 + {3'h0, ctrl_reg.stop_bits_select});
   wire logic tx_bit_end = tx_busy & tick & (tx_cnt_reg == spb_last);
   wire logic tx_finish = tx_bit_end & (tx_left_reg == 4'h0);

   // Receiver
   wire logic rx_sample = (rx_state_reg == RX_BITS) & tick & (rx_cnt_reg == spb_last);
   wire logic rx_last = rx_sample & (rx_left_reg == 4'h0);
   wire logic [9:0] rx_full = {rxd, rx_shift_reg[9:1]};
   wire logic [9:0] rx_val = rx_full >> (4'(`UMPA_RXSH_W - nbits - 4'h1));
   wire logic rx_stop = rx_val[nbits];
   wire logic rx_type = nine ? rx_val[8] : rx_stop;
   wire logic rx_drop = ctrl_reg.addr_filter_en & ~rx_type;
   wire logic rx_store = rx_last & ~rx_drop;
   wire logic rd_clear = rd_done & hit_data;

   // Sticky events: set wins over the clear of the same cycle
   wire logic [3:0] ev_set = {rx_store & irq_stat_reg.rx_complete_flag & ~rd_clear,
      rx_store & ~rx_stop, tx_finish, rx_store};
   wire logic [3:0] ev_clr = (wr_done & hit_iclr) ? apb_req.pwdata[3:0] : 4'h0;
   wire logic [3:0] irq_stat_next;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_irq
         if (gi == 0) begin : g_rxc
            assign irq_stat_next[gi] = ev_set[gi] | (irq_stat_reg[gi] & ~ev_clr[gi] & ~rd_clear);
         end else begin : g_oth
            assign irq_stat_next[gi] = ev_set[gi] | (irq_stat_reg[gi] & ~ev_clr[gi]);
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         pready_reg <= acc_first;
         pslverr_reg <= acc_first & ~mapped;
         if (acc_first) begin
            prdata_reg <= rd_word;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `UMPA_CTRL_RST;
         baud_reg <= `UMPA_BAUD_RST;
         ien_reg <= `UMPA_IRQ_RST;
         irq_stat_reg <= `UMPA_IRQ_RST;
         irq_reg <= 1'b0;
      end else begin
         if (wr_done & hit_ctrl) begin
            ctrl_reg <= apb_req.pwdata[8:0];
         end
         if (wr_done & hit_baud) begin
            baud_reg <= apb_req.pwdata[11:0];
         end
         if (wr_done & hit_ien) begin
            ien_reg <= apb_req.pwdata[3:0];
         end
         irq_stat_reg <= irq_stat_next;
         irq_reg <= |(irq_stat_next & ien_reg);
      end
   end

   // Prescaler reloads from the divisor, one tick per divisor plus one clocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_reg <= `UMPA_BAUD_RST;
      end else begin
         presc_reg <= tick ? baud_reg : presc_reg - 12'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= 12'hFFF;
         tx_left_reg <= 4'h0;
         tx_cnt_reg <= 5'h00;
         txd_reg <= 1'b1;
      end else if (tx_load) begin
         tx_state_reg <= TX_SEND;
         tx_shift_reg <= tx_frame;
         tx_left_reg <= tx_total;
         tx_cnt_reg <= 5'h00;
         txd_reg <= 1'b1;
      end else if (tx_busy) begin
         txd_reg <= tx_shift_reg[0];
         if (tick) begin
            tx_cnt_reg <= tx_bit_end ? 5'h00 : tx_cnt_reg + 5'h01;
         end
         if (tx_bit_end) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
            tx_left_reg <= tx_left_reg - 4'h1;
         end
         if (tx_finish) begin
            tx_state_reg <= TX_IDLE;
            txd_reg <= 1'b1;
         end
      end
   end

   // Start is qualified at mid bit; a short glitch returns to idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state_reg <= RX_IDLE;
         rx_shift_reg <= 10'h000;
         rx_left_reg <= 4'h0;
         rx_cnt_reg <= 5'h00;
      end else begin
         case (rx_state_reg)
            RX_IDLE: begin
               rx_cnt_reg <= 5'h00;
               if (tick & ~rxd & ctrl_reg.rx_en) begin
                  rx_state_reg <= RX_START;
               end
            end
            RX_START: begin
               if (tick) begin
                  rx_cnt_reg <= rx_cnt_reg + 5'h01;
                  if (rx_cnt_reg == spb_half) begin
                     rx_cnt_reg <= 5'h00;
                     rx_left_reg <= nbits;
                     rx_state_reg <= rxd ? RX_IDLE : RX_BITS;
                  end
               end
            end
            RX_BITS: begin
               if (tick) begin
                  rx_cnt_reg <= rx_sample ? 5'h00 : rx_cnt_reg + 5'h01;
               end
               if (rx_sample) begin
                  rx_shift_reg <= rx_full;
                  rx_left_reg <= rx_left_reg - 4'h1;
               end
               if (rx_last) begin
                  rx_state_reg <= RX_IDLE;
               end
            end
            default: begin
               rx_state_reg <= RX_IDLE;
            end
         endcase
      end
   end

   // Only accepted frames reach the buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_data_reg <= 8'h00;
         rx_ninth_reg <= 1'b0;
      end else if (rx_store) begin
         rx_data_reg <= rx_val[7:0];
         rx_ninth_reg <= nine & rx_val[8];
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign txd = txd_reg;
   assign irq = irq_reg;
endmodule : umpa_top
`default_nettype wire

// *** testbench/umpa_peer.sv ***
// Far-end station on the shared serial line.
// Assumes divisor 0 at normal speed: 16 clocks a bit.
`timescale 1ns/100ps
`default_nettype none
module umpa_peer (
   input wire logic pclk, // Clock
   output var logic rxd, // Line into the block
   input wire logic txd // Line out of the block
);
   initial rxd = 1'b1;
   // Start, n bits LSB first, then a high stop
   task send(input logic [9:0] v, input int n);
      for (int i = -1; i <= n; i++) begin
         rxd <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : v[i];
         repeat (16) @(posedge pclk);
      end
   endtask : send
   task recv(output logic [8:0] v);
      while (txd !== 1'b0) begin
         @(posedge pclk);
      end
      repeat (8) @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
         repeat (16) @(posedge pclk);
         v[i] = txd;
      end
   endtask : recv
endmodule : umpa_peer
`default_nettype wire

// *** testbench/umpa_assertions.sv ***
// Port-level checks of the transceiver.
// Assumes it is bound into umpa_top.
`timescale 1ns/100ps
`default_nettype none
module umpa_assertions (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire umpa_pkg::umpa_apb_req_t apb_req, // APB request
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic rxd, // Serial in
   input wire logic txd, // Serial out
   input wire logic irq // Interrupt
);
   import umpa_pkg::*;
   logic wr_done;
   logic [11:0] div_reg;
   logic dbl_reg;
   logic [3:0] ien_reg;
   logic [15:0] low_reg;
   assign wr_done = apb_req.psel && apb_req.penable && pready && apb_req.pwrite && !pslverr;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 12'h000;
         dbl_reg <= 1'b0;
         ien_reg <= 4'h0;
         low_reg <= 16'h0000;
      end else begin
         low_reg <= txd ? 16'h0000 : low_reg + 16'h0001;
         if (wr_done && apb_req.paddr == 8'h08) div_reg <= apb_req.pwdata[11:0];
         if (wr_done && apb_req.paddr == 8'h04) dbl_reg <= apb_req.pwdata[1];
         if (wr_done && apb_req.paddr == 8'h14) ien_reg <= apb_req.pwdata[3:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_READY_PULSE: assert property (pready |=> !pready) else $error("pready too long");
   AST_READY_IN_ACCESS: assert property (pready |-> apb_req.psel && apb_req.penable) else $error("stray pready");
   AST_ONE_WAIT: assert property ($rose(apb_req.penable) && apb_req.psel |-> !pready ##1 pready)
      else $error("access not two cycles");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("pslverr without pready");
   AST_UNMAPPED: assert property (pready && apb_req.paddr > 8'h14 |-> pslverr) else $error("no error");
   AST_MAPPED: assert property (pready && apb_req.paddr <= 8'h14 && apb_req.paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("error on mapped");
   AST_ERR_DATA_ZERO: assert property (pslverr |-> prdata == 32'h00000000) else $error("data on error");
   AST_BIT_TIME: assert property ($rose(txd) && div_reg == 12'h000 |->
      low_reg[2:0] == 3'h0 && (dbl_reg || !low_reg[3])) else $error("bit time wrong");
   AST_IRQ_MASKED: assert property (ien_reg == 4'h0 && $past(ien_reg) == 4'h0 |-> !irq) else $error("irq masked");
   cover property (wr_done);
   cover property (pslverr);
   cover property ($rose(txd));
   cover property ($rose(irq));
   cover property ($fell(rxd));
endmodule : umpa_assertions
bind umpa_top umpa_assertions i_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench of the transceiver over APB and the serial line.
// Assumes umpa_peer on the line and the checker bound in.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import umpa_pkg::*;
   logic pclk;
   logic presetn;
   umpa_apb_req_t apb_req;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rxd;
   logic txd;
   logic irq;
   logic [31:0] rd;
   logic err;
   logic [8:0] cap;
   int fail_count;
   int samples_checked;
   umpa_top i_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
   umpa_peer i_peer (.pclk(pclk), .rxd(rxd), .txd(txd));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      apb_req <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'b1, penable: 1'b0};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : apb
   task t_regs;
      apb(0, 8'h04, 0);
      chk(rd, 0);
      apb(0, 8'h08, 0);
      chk(rd, 0);
      apb(1, 8'h08, 32'h00000ABC);
      apb(0, 8'h08, 0);
      chk(rd, 32'h00000ABC);
      apb(1, 8'h08, 0);
      // The prescaler runs out the long period it loaded before divisor 0 takes hold
      repeat (2800) @(posedge pclk);
      apb(1, 8'h0C, 32'h0000000F);
      apb(0, 8'h0C, 0);
      chk(rd, 0);
      apb(0, 8'h18, 0);
      chk(err, 1);
      chk(rd, 0);
      $display("t_regs done");
   endtask : t_regs
   task t_tx;
      for (int k = 0; k < 2; k++) begin
         // Filter left on: transmitter must ignore it
         apb(1, 8'h04, 32'h000000B9 | (k << 6));
         apb(1, 8'h00, 32'h000000A5);
         i_peer.recv(cap);
         chk(cap, {k[0], 8'hA5});
         repeat (24) @(posedge pclk);
      end
      $display("t_tx done");
   endtask : t_tx
   task t_baud;
      int len;
      for (int k = 0; k < 2; k++) begin
         // Exact divisions only, so the achieved rate has zero error
         apb(1, 8'h08, 1 - k);
         apb(1, 8'h04, 32'h00000098 | (k << 1));
         apb(1, 8'h00, 32'h00000001);
         while (txd !== 1'b0) begin
            @(posedge pclk);
         end
         while (txd !== 1'b1) begin
            @(posedge pclk);
         end
         // Width of the lone high data bit
         len = 0;
         while (txd === 1'b1) begin
            @(posedge pclk);
            len++;
         end
         chk(len, (k == 1) ? 8 : 32);
         repeat (400) @(posedge pclk);
      end
      $display("t_baud done");
   endtask : t_baud
   task t_irq;
      // The interrupt follows an enable write one clock late
      apb(1, 8'h14, 2);
      repeat (2) @(posedge pclk);
      chk(irq, 1);
      apb(1, 8'h14, 0);
      repeat (2) @(posedge pclk);
      chk(irq, 0);
      apb(1, 8'h14, 2);
      repeat (2) @(posedge pclk);
      chk(irq, 1);
      apb(1, 8'h10, 2);
      repeat (2) @(posedge pclk);
      chk(irq, 0);
      apb(0, 8'h0C, 0);
      chk(rd, 0);
      apb(1, 8'h14, 0);
      $display("t_irq done");
   endtask : t_irq
   task rx_step(input logic [31:0] c, input logic [9:0] f, input logic [31:0] s, input logic [31:0] d,
      input logic [31:0] m);
      apb(1, 8'h04, c);
      i_peer.send(f, 9);
      repeat (4) @(posedge pclk);
      apb(0, 8'h0C, 0);
      chk(rd, s);
      apb(0, 8'h00, 0);
      chk(rd & m, d);
   endtask : rx_step
   task t_rx9;
      rx_step(32'h139, 10'h055, 0, 0, 32'h1FF);
      rx_step(32'h139, 10'h13C, 1, 32'h13C, 32'h1FF);
      rx_step(32'h138, 10'h066, 1, 32'h066, 32'h1FF);
      rx_step(32'h139, 10'h077, 0, 32'h066, 32'h1FF);
      $display("t_rx9 done");
   endtask : t_rx9
   task t_rx8;
      rx_step(32'h119, 10'h0AA, 0, 32'h66, 32'hFF);
      rx_step(32'h119, 10'h1C3, 1, 32'hC3, 32'hFF);
      $display("t_rx8 done");
   endtask : t_rx8
   task t_err;
      // Filter off: a low first stop is a frame error, a second store an overrun
      apb(1, 8'h04, 32'h00000118);
      i_peer.send(10'h05A, 9);
      i_peer.send(10'h1A5, 9);
      repeat (4) @(posedge pclk);
      apb(0, 8'h0C, 0);
      chk(rd, 32'h0000000D);
      apb(0, 8'h00, 0);
      chk(rd, 32'h000000A5);
      apb(1, 8'h10, 32'h0000000F);
      apb(0, 8'h0C, 0);
      chk(rd, 0);
      $display("t_err done");
   endtask : t_err
   task final_report;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report
   initial begin
      #200000;
      fail_count++;
      final_report;
   end
   initial begin
      fail_count = 0;
      samples_checked = 0;
      presetn = 1'b0;
      apb_req = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_tx;
      t_baud;
      t_irq;
      t_rx9;
      t_rx8;
      t_err;
      final_report;
   end
endmodule : testbench
`default_nettype wire
